// *** src/sdx_alu.sv ***
// Shared constants and the combinational subtract/decrement unit
// ----------------------------------------------------------------
// Constants
// ----------------------------------------------------------------
package sdx_pkg;
  localparam int          DATA_W    = 8;
  localparam int          FLAG_W    = 6;
  localparam int          NIB_W     = 4;
  // Flag vector bit positions
  localparam int          FLAG_C    = 0;
  localparam int          FLAG_AC   = 1;
  localparam int          FLAG_Z    = 2;
  localparam int          FLAG_OV   = 3;
  localparam int          FLAG_SC   = 4;
  localparam int          FLAG_CZ   = 5;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [5:0]  FLAGS_RST = 6'h00;
  localparam logic [7:0]  ZERO      = 8'h00;
  localparam logic [7:0]  ONE       = 8'h01;
  localparam logic [7:0]  ALL_ONES  = 8'hff;

  typedef enum logic [1:0] {
    OP_SUB_BORROW_MEM                = 2'h0,
    OP_DECREMENT_SKIP_IF_ZERO        = 2'h1,
    OP_DECREMENT_TO_ACC_SKIP_IF_ZERO = 2'h2,
    OP_RESERVED                      = 2'h3
  } sdx_op_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_DUMMY = 2'b10
  } sdx_state_t;
endpackage : sdx_pkg

// ----------------------------------------------------------------
// Arithmetic unit
// ----------------------------------------------------------------
module sdx_alu (
  input  wire sdx_pkg::sdx_op_t opKind,      // Instruction being executed
  input  wire logic [7:0]       accIn,       // Accumulator value
  input  wire logic [7:0]       memIn,       // Addressed memory byte
  input  wire logic [5:0]       flagsIn,     // Current flags
  output logic      [7:0]       result,      // Arithmetic result
  output logic      [5:0]       flagsOut,    // Flags after the operation
  output logic                  resultZero   // Result equals zero
);
  logic       borrow;
  logic [8:0] diffFull;
  logic [4:0] lowDiff;

  always_comb begin
    borrow   = ~flagsIn[sdx_pkg::FLAG_C];
    // Nine bits so the borrow out is visible
    diffFull = {1'b0, accIn} - {1'b0, memIn} - {8'h00, borrow};
    lowDiff  = {1'b0, accIn[3:0]} - {1'b0, memIn[3:0]} - {4'h0, borrow};
    flagsOut = flagsIn;
    if (opKind == sdx_pkg::OP_SUB_BORROW_MEM) begin
      result                     = diffFull[7:0];
      flagsOut[sdx_pkg::FLAG_C]  = ~diffFull[sdx_pkg::DATA_W];
      flagsOut[sdx_pkg::FLAG_AC] = ~lowDiff[sdx_pkg::NIB_W];
      flagsOut[sdx_pkg::FLAG_Z]  = (diffFull[7:0] == sdx_pkg::ZERO);
      flagsOut[sdx_pkg::FLAG_OV] = (accIn[7] ^ memIn[7]) & (accIn[7] ^ diffFull[7]);
      flagsOut[sdx_pkg::FLAG_SC] = flagsOut[sdx_pkg::FLAG_OV] ^ diffFull[7];
      // Chained compare: zero only if the earlier byte was zero too
      flagsOut[sdx_pkg::FLAG_CZ] = flagsOut[sdx_pkg::FLAG_Z] & flagsIn[sdx_pkg::FLAG_CZ];
    end else begin
      result = memIn - sdx_pkg::ONE;
    end
    resultZero = (result == sdx_pkg::ZERO);
  end
endmodule : sdx_alu

// *** src/sdx_exec.sv ***
// Execution unit for subtract-borrow-to-memory and the two decrement-skip instructions
module sdx_exec (
  input  wire logic              clk_sys,               // System clock, 100 MHz
  input  wire logic              srst,                  // Synchronous reset, active high
  input  wire logic              opValid,               // Instruction offered
  input  wire sdx_pkg::sdx_op_t  opKind,                // Which instruction
  input  wire logic [7:0]        opAddr,                // Memory address of operand
  input  wire logic [7:0]        memRdData,             // Operand byte at opAddr
  input  wire logic              accWrEn,               // Core loads accumulator
  input  wire logic [7:0]        accWrData,             // Accumulator load value
  input  wire logic              flagWrEn,              // Core loads flags
  input  wire logic [5:0]        flagWrData,            // Flag load value
  output logic                   opReady,               // Instruction can be taken
  output logic                   memWrEn,               // Memory write pulse
  output logic      [7:0]        memWrAddr,             // Memory write address
  output logic      [7:0]        memWrData,             // Memory write data
  output logic      [7:0]        accumulatorReg,        // Accumulator
  output logic                   carryFlag,             // C
  output logic                   auxCarryFlag,          // AC
  output logic                   zeroFlag,              // Z
  output logic                   overflowFlag,          // OV
  output logic                   signedCompareFlag,     // SC
  output logic                   combinedCarryZeroFlag, // CZ
  output logic                   skipTaken,             // Pulse: next instruction skipped
  output logic                   dummyCycle             // Level: dummy slot in progress
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sdx_pkg::sdx_state_t state;
    logic [7:0]          acc;
    logic [5:0]          flags;
    logic                memWrEn;
    logic [7:0]          memWrAddr;
    logic [7:0]          memWrData;
    logic                skip;
  } sdx_regs_t;

  sdx_regs_t  r;
  sdx_regs_t  next_r;
  logic [7:0] aluResult;
  logic [5:0] aluFlags;
  logic       aluZero;
  logic       take;
  logic       validOp;

  sdx_alu u_alu (
    .opKind     (opKind),
    .accIn      (r.acc),
    .memIn      (memRdData),
    .flagsIn    (r.flags),
    .result     (aluResult),
    .flagsOut   (aluFlags),
    .resultZero (aluZero)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // No new instruction while the dummy slot runs
  assign opReady = (r.state == sdx_pkg::ST_RUN);
  // Reserved code acts as an idle slot, so core loads still land
  assign validOp = (opKind != sdx_pkg::OP_RESERVED);
  assign take    = opValid && opReady && validOp;

  always_comb begin
    next_r         = r;
    next_r.memWrEn = 1'b0;
    next_r.skip    = 1'b0;
    case (r.state)
      sdx_pkg::ST_RUN: begin
        if (take) begin
          case (opKind)
            sdx_pkg::OP_SUB_BORROW_MEM: begin
              next_r.memWrEn   = 1'b1;
              next_r.memWrAddr = opAddr;
              next_r.memWrData = aluResult;
              next_r.flags     = aluFlags;
            end
            sdx_pkg::OP_DECREMENT_SKIP_IF_ZERO: begin
              next_r.memWrEn   = 1'b1;
              next_r.memWrAddr = opAddr;
              next_r.memWrData = aluResult;
              next_r.skip      = aluZero;
            end
            sdx_pkg::OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: begin
              next_r.acc  = aluResult;
              next_r.skip = aluZero;
            end
            default: begin
              next_r.skip = 1'b0;
            end
          endcase
          if (next_r.skip) begin
            next_r.state = sdx_pkg::ST_DUMMY;
          end
        end else begin
          if (accWrEn) begin
            next_r.acc = accWrData;
          end
          if (flagWrEn) begin
            next_r.flags = flagWrData;
          end
        end
      end
      sdx_pkg::ST_DUMMY: begin
        // Slot is burnt; loads from the core are ignored too
        next_r.state = sdx_pkg::ST_RUN;
      end
      default: begin
        next_r.state = sdx_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r.state     <= sdx_pkg::ST_RUN;
      r.acc       <= sdx_pkg::ACC_RST;
      r.flags     <= sdx_pkg::FLAGS_RST;
      r.memWrEn   <= 1'b0;
      r.memWrAddr <= sdx_pkg::ZERO;
      r.memWrData <= sdx_pkg::ZERO;
      r.skip      <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign memWrEn               = r.memWrEn;
  assign memWrAddr             = r.memWrAddr;
  assign memWrData             = r.memWrData;
  assign accumulatorReg        = r.acc;
  assign carryFlag             = r.flags[sdx_pkg::FLAG_C];
  assign auxCarryFlag          = r.flags[sdx_pkg::FLAG_AC];
  assign zeroFlag              = r.flags[sdx_pkg::FLAG_Z];
  assign overflowFlag          = r.flags[sdx_pkg::FLAG_OV];
  assign signedCompareFlag     = r.flags[sdx_pkg::FLAG_SC];
  assign combinedCarryZeroFlag = r.flags[sdx_pkg::FLAG_CZ];
  assign skipTaken             = r.skip;
  assign dummyCycle            = (r.state == sdx_pkg::ST_DUMMY);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic takeSub;
  logic takeDec;
  logic takeDecAcc;
  logic subNoBorrow;
  logic [8:0] subWide;
  logic       auxNoBorrow;
  assign takeSub     = take && (opKind == sdx_pkg::OP_SUB_BORROW_MEM);
  assign takeDec     = take && (opKind == sdx_pkg::OP_DECREMENT_SKIP_IF_ZERO);
  assign takeDecAcc  = take && (opKind == sdx_pkg::OP_DECREMENT_TO_ACC_SKIP_IF_ZERO);
  assign subNoBorrow = {1'b0, r.acc} >= ({1'b0, memRdData} + {8'h00, ~carryFlag});
  // Sign-extended reference, so overflow is judged apart from the unit's own formula
  assign subWide     = {r.acc[7], r.acc} - {memRdData[7], memRdData} - {8'h00, ~carryFlag};
  assign auxNoBorrow = {1'b0, r.acc[3:0]} >= ({1'b0, memRdData[3:0]} + {4'h0, ~carryFlag});

  sub_result_a: assert property (takeSub |=> memWrData == $past(r.acc - memRdData - {7'h00, ~carryFlag}))
    else $error("Subtract result wrong");
  sub_dest_a: assert property (takeSub |=> memWrEn && memWrAddr == $past(opAddr) && $stable(accumulatorReg))
    else $error("Subtract result not sent to memory");
  sub_carry_a: assert property (takeSub |=> carryFlag == $past(subNoBorrow))
    else $error("Subtract carry wrong");
  sub_flags_a: assert property (takeSub |=> zeroFlag == (memWrData == sdx_pkg::ZERO)
                                  && signedCompareFlag == (overflowFlag ^ memWrData[7]))
    else $error("Subtract flags wrong");
  sub_ovf_a: assert property (takeSub |=> overflowFlag == $past(subWide[sdx_pkg::DATA_W] ^ subWide[7]))
    else $error("Subtract overflow flag wrong");
  sub_aux_a: assert property (takeSub |=> auxCarryFlag == $past(auxNoBorrow))
    else $error("Subtract aux carry flag wrong");
  sub_chain_a: assert property (takeSub |=> combinedCarryZeroFlag ==
                                  (zeroFlag && $past(combinedCarryZeroFlag)))
    else $error("Subtract chained zero flag wrong");
  dec_mem_a: assert property (takeDec |=> memWrEn && memWrData == $past(memRdData) - sdx_pkg::ONE
                                && $stable(accumulatorReg) && $stable(r.flags))
    else $error("Decrement to memory wrong");
  skip_slot_a: assert property ((takeDec || takeDecAcc) && memRdData == sdx_pkg::ONE
                                  |=> skipTaken && dummyCycle && !opReady ##1 opReady && !dummyCycle)
    else $error("Skip slot not exactly one dummy cycle");
  no_skip_a: assert property ((takeDec || takeDecAcc) && memRdData != sdx_pkg::ONE
                                |=> !skipTaken && opReady)
    else $error("Skip taken on nonzero result");
  dec_acc_a: assert property (takeDecAcc |=> !memWrEn && accumulatorReg == $past(memRdData) - sdx_pkg::ONE
                                && $stable(r.flags))
    else $error("Decrement to accumulator wrong");
  acc_skip_a: assert property (takeDecAcc |=> skipTaken == (accumulatorReg == sdx_pkg::ZERO))
    else $error("Accumulator skip mismatch");
  dummy_quiet_a: assert property (dummyCycle |=> $stable(accumulatorReg) && $stable(r.flags) && !memWrEn)
    else $error("Dummy cycle changed state");
  wrap_dec_a: assert property (takeDec && memRdData == sdx_pkg::ZERO
                                 |=> memWrData == sdx_pkg::ALL_ONES && !skipTaken)
    else $error("Decrement wrap wrong");
  wrap_acc_a: assert property (takeDecAcc && memRdData == sdx_pkg::ZERO
                                 |=> accumulatorReg == sdx_pkg::ALL_ONES && !skipTaken)
    else $error("Decrement to accumulator wrap wrong");
  dummy_once_a: assert property (dummyCycle |=> !dummyCycle && opReady)
    else $error("Dummy slot longer than one cycle");

  // Main scenarios reached
  sub_seen_c: cover property (takeSub ##1 carryFlag == 1'b0);
  dummy_load_c: cover property (dummyCycle && accWrEn);
  dec_skip_c: cover property (takeDec && memRdData == sdx_pkg::ONE ##1 skipTaken);
  acc_skip_c: cover property (takeDecAcc && memRdData == sdx_pkg::ONE ##2 take);
  wrap_c:     cover property (takeDec && memRdData == sdx_pkg::ZERO);
endmodule : sdx_exec

// *** verification/tb.sv ***
// Self-checking bench for the subtract and decrement-skip execution unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_sys;
  logic             srst;
  logic             opValid;
  sdx_pkg::sdx_op_t opKind;
  logic [7:0]       opAddr;
  logic [7:0]       memRdData;
  logic             accWrEn;
  logic [7:0]       accWrData;
  logic             flagWrEn;
  logic [5:0]       flagWrData;
  logic             opReady;
  logic             memWrEn;
  logic [7:0]       memWrAddr;
  logic [7:0]       memWrData;
  logic [7:0]       accumulatorReg;
  logic             carryFlag;
  logic             auxCarryFlag;
  logic             zeroFlag;
  logic             overflowFlag;
  logic             signedCompareFlag;
  logic             combinedCarryZeroFlag;
  logic             skipTaken;
  logic             dummyCycle;
  logic [31:0]      rnd;
  logic [7:0]       eAcc;
  logic [5:0]       eFlg;
  logic [7:0]       eWrAddr;
  logic [7:0]       eWrData;
  int               n_mismatch;
  int               n_checks;

  sdx_exec dut (.clk_sys(clk_sys), .srst(srst), .opValid(opValid), .opKind(opKind), .opAddr(opAddr),
    .memRdData(memRdData), .accWrEn(accWrEn), .accWrData(accWrData), .flagWrEn(flagWrEn),
    .flagWrData(flagWrData), .opReady(opReady), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .accumulatorReg(accumulatorReg), .carryFlag(carryFlag),
    .auxCarryFlag(auxCarryFlag), .zeroFlag(zeroFlag), .overflowFlag(overflowFlag),
    .signedCompareFlag(signedCompareFlag), .combinedCarryZeroFlag(combinedCarryZeroFlag),
    .skipTaken(skipTaken), .dummyCycle(dummyCycle));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Expected {flags, difference} of the subtract: C and AC mean no borrow
  function automatic logic [13:0] sub_expect(input logic [7:0] acc, input logic [7:0] m, input logic [5:0] f);
    logic [8:0] d;
    logic [4:0] n;
    logic       ov;
    d  = {1'b0, acc} - {1'b0, m} - {8'h00, ~f[0]};
    n  = {1'b0, acc[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f[0]};
    ov = (acc[7] != m[7]) && (d[7] != acc[7]);
    return {(d[7:0] == 8'h00) & f[5], ov ^ d[7], ov, d[7:0] == 8'h00, ~n[4], ~d[8], d[7:0]};
  endfunction : sub_expect

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask : chk

  task automatic check(input logic wr, input logic sk);
    chk("memWrEn", {7'h00, wr}, {7'h00, memWrEn});
    chk("memWrAddr", eWrAddr, memWrAddr);
    chk("memWrData", eWrData, memWrData);
    chk("accumulatorReg", eAcc, accumulatorReg);
    chk("flags", {2'b00, eFlg}, {2'b00, combinedCarryZeroFlag, signedCompareFlag, overflowFlag, zeroFlag,
        auxCarryFlag, carryFlag});
    chk("skipTaken", {7'h00, sk}, {7'h00, skipTaken});
    chk("dummyCycle", {7'h00, sk}, {7'h00, dummyCycle});
    chk("opReady", {7'h00, ~sk}, {7'h00, opReady});
  endtask : check

  task automatic load(input logic [7:0] a, input logic [5:0] f);
    @(posedge clk_sys);
    accWrEn    <= 1'b1;
    flagWrEn   <= 1'b1;
    accWrData  <= a;
    flagWrData <= f;
    @(posedge clk_sys);
    accWrEn  <= 1'b0;
    flagWrEn <= 1'b0;
    eAcc = a;
    eFlg = f;
    #1;
    check(1'b0, 1'b0);
  endtask : load

  // Offers one op, then a refused op plus core loads during any dummy slot
  task automatic run_op(input logic [1:0] k, input logic [7:0] a, input logic [7:0] m);
    logic [13:0] s;
    logic [7:0]  r;
    logic        wr;
    logic        sk;
    for (int i = 0; i < 4 && opReady !== 1'b1; i++) @(posedge clk_sys);
    if (opReady !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
    @(posedge clk_sys);
    opValid   <= 1'b1;
    opKind    <= sdx_pkg::sdx_op_t'(k);
    opAddr    <= a;
    memRdData <= m;
    wr = 1'b0;
    sk = 1'b0;
    r  = m - 8'h01;
    if (k == 2'd0) begin
      s    = sub_expect(eAcc, m, eFlg);
      r    = s[7:0];
      eFlg = s[13:8];
    end else if (k == 2'd2) begin
      eAcc = r;
      sk   = (r == 8'h00);
    end else if (k == 2'd1) begin
      sk = (r == 8'h00);
    end
    if (k < 2'd2) begin
      wr      = 1'b1;
      eWrData = r;
      eWrAddr = a;
    end
    @(posedge clk_sys);
    opValid    <= sk;
    accWrEn    <= sk;
    flagWrEn   <= sk;
    accWrData  <= rnd[7:0];
    flagWrData <= ~eFlg;
    #1;
    check(wr, sk);
    if (sk) begin
      @(posedge clk_sys);
      opValid  <= 1'b0;
      accWrEn  <= 1'b0;
      flagWrEn <= 1'b0;
      #1;
      check(1'b0, 1'b0);
    end
  endtask : run_op

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    srst       = 1'b1;
    opValid    = 1'b0;
    opKind     = sdx_pkg::OP_SUB_BORROW_MEM;
    opAddr     = 8'h00;
    memRdData  = 8'h00;
    accWrEn    = 1'b0;
    accWrData  = 8'h00;
    flagWrEn   = 1'b0;
    flagWrData = 6'h00;
    rnd        = 32'h5c20_638a;
    eAcc       = 8'h00;
    eFlg       = 6'h00;
    eWrAddr    = 8'h00;
    eWrData    = 8'h00;
    n_mismatch = 0;
    n_checks   = 0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check(1'b0, 1'b0);
    load(8'h10, 6'h21);
    run_op(2'd0, 8'h20, 8'h10);
    run_op(2'd0, 8'h21, 8'h01);
    load(8'h00, 6'h00);
    run_op(2'd0, 8'h22, 8'h01);
    load(8'h80, 6'h01);
    run_op(2'd0, 8'h23, 8'h01);
    run_op(2'd1, 8'h30, 8'h01);
    run_op(2'd1, 8'h31, 8'h00);
    run_op(2'd2, 8'h32, 8'h01);
    run_op(2'd2, 8'h33, 8'h00);
    run_op(2'd3, 8'h34, 8'h55);
    $display("test corner cases done");
    for (int i = 0; i < 300; i++) begin
      rnd = lfsr_next(rnd);
      if (rnd[28:27] == 2'd0) begin
        load(rnd[7:0], rnd[13:8]);
      end
      run_op(rnd[17:16], rnd[23:16], rnd[25] ? {7'h00, rnd[24]} : rnd[15:8]);
    end
    $display("test random ops done");
    close_out();
  end
endmodule : tb
